// ---- tb.sv ----
// self-checking bench for the rule programmer against the device model
// assumes a shortened bring-up clear of sixteen addresses
`timescale 1ns/1ps
module tb;
	localparam int IW = 16; // addresses cleared at bring-up
	localparam int EW = tcw_pkg::ENTRY_W; // entry bits per address
	localparam int AW = tcw_pkg::ACTION_W; // action bits per address
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic init_start = 1'b0;
	logic alloc_done = 1'b0;
	logic req_valid = 1'b0;
	logic [1:0] req_op = 2'h0;
	logic [tcw_pkg::ADDR_W-1:0] req_addr = 13'h0;
	logic [2:0] req_esize = 3'h0;
	logic [1:0] req_asize = 2'h0;
	logic [tcw_pkg::MAX_WORDS*EW-1:0] req_entry;
	logic [tcw_pkg::MAX_WORDS*EW-1:0] req_mask;
	logic [tcw_pkg::ACT_WORDS*AW-1:0] req_action;
	logic lookup_en, req_ready, done, err, dev_wr, dev_ack;
	logic [tcw_pkg::ADDR_W-1:0] dev_addr;
	logic [EW-1:0] dev_entry, dev_mask;
	logic [AW-1:0] dev_action;
	logic [tcw_pkg::CNT_W-1:0] dev_cnt;
	logic [3:0] dly = 4'h0; // device ack latency
	int failures = 0;
	int cmp_count = 0;
	int cyc = 0;
	// 25 MHz clock
	always #20 clk = ~clk;
	tcw_host #(.INIT_WORDS(IW)) tcw_host_inst (.clk_i(clk), .nrst_i(nrst),
		.init_start_i(init_start), .alloc_done_i(alloc_done), .lookup_en_o(lookup_en),
		.req_valid_i(req_valid), .req_op_i(req_op), .req_addr_i(req_addr),
		.req_esize_i(req_esize), .req_asize_i(req_asize), .req_entry_i(req_entry),
		.req_mask_i(req_mask), .req_action_i(req_action), .req_ready_o(req_ready),
		.done_o(done), .err_o(err), .dev_addr_o(dev_addr), .dev_entry_o(dev_entry),
		.dev_mask_o(dev_mask), .dev_action_o(dev_action), .dev_cnt_o(dev_cnt),
		.dev_wr_o(dev_wr), .dev_ack_i(dev_ack));
	tcw_dev_model tcw_dev_model_inst (.clk_i(clk), .addr_i(dev_addr), .entry_i(dev_entry),
		.mask_i(dev_mask), .action_i(dev_action), .cnt_i(dev_cnt), .wr_i(dev_wr),
		.ack_o(dev_ack), .dly_i(dly));
	// compare and count
	task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// verdict and end of run
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : tally_and_finish
	// hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			tally_and_finish();
		end
	end
	// number of trailing zero bits of an offset
	function automatic int tz(input int k);
		int t;
		t = 0;
		while (k[t] == 1'b0 && t < 4) t++;
		return t;
	endfunction : tz
	// word with its low bits replaced by the marker of offset k, part size 2**s
	function automatic logic [127:0] tg(input logic [127:0] w, input int k, input int s,
		input logic is_msk);
		int wd;
		logic [4:0] v;
		wd = (k == 0) ? s + 1 : tz(k) + 1;
		v = (k == 0 && !is_msk) ? 5'(1 << s) : 5'h0;
		for (int i = 0; i < wd; i++) w[i] = v[i];
		return w;
	endfunction : tg
	// hand one request over when ready and wait for done or refusal
	task automatic issue(input logic init, input logic [1:0] op, input int a,
		input logic [2:0] es, input logic [1:0] as, output logic got_err);
		int n;
		n = 0;
		while (req_ready !== 1'b1 && n < 100) begin
			@(posedge clk);
			#1;
			n++;
		end
		@(posedge clk);
		init_start <= init;
		req_valid <= !init;
		req_op <= op;
		req_addr <= 13'(a);
		req_esize <= es;
		req_asize <= as;
		@(posedge clk);
		init_start <= 1'b0;
		req_valid <= 1'b0;
		got_err = 1'b0;
		for (n = 0; n < 2000; n++) begin
			#1;
			if (err === 1'b1) got_err = 1'b1;
			if (err === 1'b1 || done === 1'b1) break;
			@(posedge clk);
		end
		if (n == 2000) chk(n, 0);
	endtask : issue
	// check the words of one rule as the device took them
	task automatic check_rule(input int a, input int es, input int as, input logic wr);
		int n;
		int k;
		logic [127:0] ee, mm, xx;
		n = 1 << ((es > as) ? es : as);
		for (int j = 0; j < n; j++) begin
			k = wr ? n - 1 - j : j;
			if (tcw_dev_model_inst.wlog.size() == 0) begin
				chk(0, 1);
				return;
			end
			ee = {EW{1'b1}};
			mm = {EW{1'b1}};
			xx = '0;
			if (wr && k < (1 << es)) begin
				ee = tg(req_entry[k*EW+:EW], k, es, 1'b0);
				mm = tg(req_mask[k*EW+:EW], k, es, 1'b1);
			end
			if (wr && k < (1 << as)) xx = tg(req_action[k*AW+:AW], k, as, 1'b0);
			chk(tcw_dev_model_inst.wlog[0].a, 13'(a + k));
			chk({tcw_dev_model_inst.wlog[0].e, tcw_dev_model_inst.wlog[0].m}, {ee[EW-1:0], mm[EW-1:0]});
			chk(tcw_dev_model_inst.wlog[0].x, xx);
			chk(tcw_dev_model_inst.wlog[0].c, 0);
			void'(tcw_dev_model_inst.wlog.pop_front());
		end
	endtask : check_rule
	// refused before bring-up, then clear, then enable after allocation
	task automatic t_bringup();
		logic e;
		issue(1'b0, 2'h1, 0, 3'h0, 2'h0, e);
		chk(e, 1);
		chk(tcw_dev_model_inst.wlog.size(), 0);
		issue(1'b1, 2'h0, 0, 3'h0, 2'h0, e);
		chk(e, 0);
		for (int a = 0; a < IW; a++) check_rule(a, 0, 0, 1'b0);
		chk(lookup_en, 0);
		@(posedge clk);
		alloc_done <= 1'b1;
		for (int n = 0; n < 8 && lookup_en !== 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		chk(lookup_en, 1);
		$display("bring-up test done");
	endtask : t_bringup
	// every entry and action size pairing, written highest address first
	task automatic t_write();
		logic e;
		for (int es = 0; es < 5; es++) begin
			for (int as = 0; as < 3; as++) begin
				issue(1'b0, 2'h1, 16 * (es * 3 + as + 1), 3'(es), 2'(as), e);
				chk(e, 0);
				check_rule(16 * (es * 3 + as + 1), es, as, 1'b1);
			end
		end
		$display("write test done");
	endtask : t_write
	// misaligned base, sizes out of range and unknown operations are refused
	task automatic t_refuse();
		logic e;
		logic [1:0] ops [5] = '{2'h1, 2'h1, 2'h1, 2'h0, 2'h3};
		int bases [5] = '{2, 0, 0, 0, 0};
		logic [2:0] ess [5] = '{3'h2, 3'h5, 3'h0, 3'h0, 3'h0};
		logic [1:0] ass [5] = '{2'h0, 2'h0, 2'h3, 2'h0, 2'h0};
		for (int i = 0; i < 5; i++) begin
			issue(1'b0, ops[i], bases[i], ess[i], ass[i], e);
			chk(e, 1);
			chk(req_ready, 1);
			chk(tcw_dev_model_inst.wlog.size(), 0);
		end
		$display("refusal test done");
	endtask : t_refuse
	// exact-match rule takes a hit, then disable at once, lowest address first
	task automatic t_disable();
		logic e;
		logic [tcw_pkg::MAX_WORDS*EW-1:0] mk;
		mk = req_mask;
		@(posedge clk);
		req_mask <= '0;
		issue(1'b0, 2'h1, 'h140, 3'h1, 2'h2, e);
		chk(e, 0);
		check_rule('h140, 1, 2, 1'b1);
		tcw_dev_model_inst.hit('h140, 2);
		tcw_dev_model_inst.hit('h140, 2);
		chk(tcw_dev_model_inst.mem_c['h140], 1);
		chk(tcw_dev_model_inst.mem_c['h141], 0);
		issue(1'b0, 2'h2, 'h140, 3'h1, 2'h2, e);
		chk(e, 0);
		check_rule('h140, 1, 2, 1'b0);
		chk(tcw_dev_model_inst.live('h140), 0);
		@(posedge clk);
		req_mask <= mk;
		$display("disable test done");
	endtask : t_disable
	// slow device ack on a two-address rule
	task automatic t_slow();
		logic e;
		@(posedge clk);
		dly <= 4'h9;
		issue(1'b0, 2'h1, 'h162, 3'h1, 2'h0, e);
		chk(e, 0);
		check_rule('h162, 1, 0, 1'b1);
		@(posedge clk);
		dly <= 4'h0;
		$display("slow ack test done");
	endtask : t_slow
	// main sequence
	initial begin
		for (int k = 0; k < tcw_pkg::MAX_WORDS; k++) begin
			req_entry[k*EW+:EW] = 36'hc3a5f0e1f ^ (36'(k) << 12);
			req_mask[k*EW+:EW] = 36'h0f0f0f0ff ^ (36'(k) << 20);
		end
		for (int k = 0; k < tcw_pkg::ACT_WORDS; k++) begin
			req_action[k*AW+:AW] = 70'h2a5555aaaa1234567f ^ (70'(k) << 40);
		end
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		t_bringup();
		t_write();
		t_refuse();
		t_disable();
		t_slow();
		tally_and_finish();
	end
endmodule : tb

// ---- tcw_dev_model.sv ----
// device side model of the classifier cache write pins
// assumes a four-phase wr/ack handshake in the host clock domain
`timescale 1ns/1ps
module tcw_dev_model (
	// clock
	input wire logic clk_i,
	// cache write pins
	input wire logic [tcw_pkg::ADDR_W-1:0] addr_i,
	input wire logic [tcw_pkg::ENTRY_W-1:0] entry_i,
	input wire logic [tcw_pkg::ENTRY_W-1:0] mask_i,
	input wire logic [tcw_pkg::ACTION_W-1:0] action_i,
	input wire logic [tcw_pkg::CNT_W-1:0] cnt_i,
	input wire logic wr_i,
	output logic ack_o,
	// ack latency in cycles
	input wire logic [3:0] dly_i
);
	// one taken word
	typedef struct packed {
		logic [tcw_pkg::ADDR_W-1:0] a;
		logic [tcw_pkg::ENTRY_W-1:0] e;
		logic [tcw_pkg::ENTRY_W-1:0] m;
		logic [tcw_pkg::ACTION_W-1:0] x;
		logic [tcw_pkg::CNT_W-1:0] c;
	} tcw_wlog_t;
	tcw_wlog_t wlog [$]; // every word taken, in order
	logic [tcw_pkg::ENTRY_W-1:0] mem_e [tcw_pkg::ADDR_SPACE];
	logic [tcw_pkg::ENTRY_W-1:0] mem_m [tcw_pkg::ADDR_SPACE];
	logic [tcw_pkg::ACTION_W-1:0] mem_x [tcw_pkg::ADDR_SPACE];
	logic [tcw_pkg::CNT_W-1:0] mem_c [tcw_pkg::ADDR_SPACE];
	logic [3:0] wait_q = 4'h0; // cycles waited before ack
	initial ack_o = 1'b0;
	// take one address per handshake after the set latency, drop ack once wr falls
	always @(posedge clk_i) begin
		if (wr_i && !ack_o) begin
			if (wait_q == dly_i) begin
				mem_e[addr_i] <= entry_i;
				mem_m[addr_i] <= mask_i;
				mem_x[addr_i] <= action_i;
				mem_c[addr_i] <= cnt_i;
				wlog.push_back({addr_i, entry_i, mask_i, action_i, cnt_i});
				ack_o <= 1'b1;
				wait_q <= 4'h0;
			end else begin
				wait_q <= wait_q + 4'h1;
			end
		end else if (!wr_i && ack_o) begin
			ack_o <= 1'b0;
		end
	end
	// an address can match unless a bit holds data and mask both one
	function automatic logic live(input int a);
		return ~|(mem_e[a] & mem_m[a]);
	endfunction : live
	// a hit on a rule of n addresses sets only the offset zero counter, saturating
	task automatic hit(input int a, input int n);
		logic ok;
		ok = 1'b1;
		for (int i = 0; i < n; i++) ok &= live(a + i);
		if (ok) mem_c[a] = 1'b1;
	endtask : hit
endmodule : tcw_dev_model

// ---- tcw_host.sv ----
// rule programmer that drives the classifier cache write pins of the device
// assumes a four-phase write handshake: the device raises ack after taking
// a word and drops it after the write strobe falls; ack arrives asynchronously
`timescale 1ns/1ps
module tcw_host #(
	parameter int INIT_WORDS = tcw_pkg::ADDR_SPACE // addresses cleared at bring-up
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// bring-up control
	input wire logic init_start_i,
	input wire logic alloc_done_i,
	output logic lookup_en_o,
	// rule request
	input wire logic req_valid_i,
	input wire logic [1:0] req_op_i,
	input wire logic [tcw_pkg::ADDR_W-1:0] req_addr_i,
	input wire logic [2:0] req_esize_i,
	input wire logic [1:0] req_asize_i,
	input wire logic [tcw_pkg::MAX_WORDS*tcw_pkg::ENTRY_W-1:0] req_entry_i,
	input wire logic [tcw_pkg::MAX_WORDS*tcw_pkg::ENTRY_W-1:0] req_mask_i,
	input wire logic [tcw_pkg::ACT_WORDS*tcw_pkg::ACTION_W-1:0] req_action_i,
	output logic req_ready_o,
	output logic done_o,
	output logic err_o,
	// device cache write pins
	output logic [tcw_pkg::ADDR_W-1:0] dev_addr_o,
	output logic [tcw_pkg::ENTRY_W-1:0] dev_entry_o,
	output logic [tcw_pkg::ENTRY_W-1:0] dev_mask_o,
	output logic [tcw_pkg::ACTION_W-1:0] dev_action_o,
	output logic [tcw_pkg::CNT_W-1:0] dev_cnt_o,
	output logic dev_wr_o,
	input wire logic dev_ack_i
);
	localparam logic [tcw_pkg::ADDR_W-1:0] INIT_LAST = tcw_pkg::ADDR_W'(INIT_WORDS - 1);
	localparam logic [tcw_pkg::ENTRY_W-1:0] ENTRY_OFF = '1; // match-off in every bit

	logic rst_meta_q; // reset release, first stage
	logic rst_nq; // synchronized active-low reset
	logic ack_s; // device ack after synchronizer
	tcw_pkg::tcw_state_t state_q; // sequencer state
	tcw_pkg::tcw_op_t op_q; // running operation
	logic [tcw_pkg::ADDR_W-1:0] base_q; // rule base, or init address
	logic [tcw_pkg::OFF_W-1:0] off_q; // offset being written
	logic [tcw_pkg::OFF_W-1:0] last_q; // last offset of the rule
	logic [2:0] esize_q; // entry size, log2
	logic [1:0] asize_q; // action size, log2
	logic [tcw_pkg::MAX_WORDS*tcw_pkg::ENTRY_W-1:0] ent_q; // entry words
	logic [tcw_pkg::MAX_WORDS*tcw_pkg::ENTRY_W-1:0] msk_q; // mask words
	logic [tcw_pkg::ACT_WORDS*tcw_pkg::ACTION_W-1:0] act_q; // action words
	logic dev_wr_q; // write strobe
	logic [tcw_pkg::ADDR_W-1:0] dev_addr_q; // word address
	logic [tcw_pkg::ENTRY_W-1:0] dev_entry_q; // entry word
	logic [tcw_pkg::ENTRY_W-1:0] dev_mask_q; // mask word
	logic [tcw_pkg::ACTION_W-1:0] dev_action_q; // action word
	logic [tcw_pkg::CNT_W-1:0] dev_cnt_q; // counter word
	logic ready_q; // idle and accepting
	logic done_q; // operation finished pulse
	logic err_q; // request refused pulse
	logic init_done_q; // whole memory cleared
	logic lookup_en_q; // lookups may run
	logic [2:0] req_nlog; // requested rule size, log2
	logic [4:0] req_last5; // requested last offset, widened
	logic [tcw_pkg::OFF_W-1:0] req_last; // requested last offset
	logic req_ok; // request is legal
	logic take_init; // bring-up clear starts
	logic take_req; // rule request is looked at
	logic final_w; // current word is the last of the operation
	logic rel_w; // handshake for the current word is complete
	logic [tcw_pkg::ENTRY_W-1:0] e_raw; // entry payload at offset
	logic [tcw_pkg::ENTRY_W-1:0] m_raw; // mask payload at offset
	logic [tcw_pkg::ACTION_W-1:0] a_raw; // action payload at offset
	logic [tcw_pkg::ENTRY_W-1:0] e_tgm; // entry marker positions
	logic [tcw_pkg::ENTRY_W-1:0] e_tgv; // entry marker value
	logic [tcw_pkg::ACTION_W-1:0] a_tgm; // action marker positions
	logic [tcw_pkg::ACTION_W-1:0] a_tgv; // action marker value

	tcw_tg_if tg ();

	// marker encoder
	tcw_marker u_marker (
		.tg(tg.enc)
	);

	// ack pin synchronizer
	tcw_sync #(
		.W(1)
	) u_ack_sync (
		.clk_i(clk_i),
		.rst_ni(rst_nq),
		.d_i(dev_ack_i),
		.q_o(ack_s)
	);

	// reset release through two flip-flops
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_meta_q <= 1'b0;
			rst_nq <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_nq <= rst_meta_q;
		end
	end

	// request checks and per-word decode
	always_comb begin
		req_nlog = (req_esize_i > {1'b0, req_asize_i}) ? req_esize_i : {1'b0, req_asize_i}; // RULE_05
		req_last5 = (5'h01 << req_nlog) - 5'h01;
		req_last = req_last5[tcw_pkg::OFF_W-1:0];
		req_ok = init_done_q && (req_esize_i <= tcw_pkg::ESIZE_MAX) // RULE_01 RULE_17
			&& (req_asize_i <= tcw_pkg::ASIZE_MAX) // RULE_17
			&& ((req_addr_i[tcw_pkg::OFF_W-1:0] & req_last) == 4'h0) // RULE_07
			&& ((req_op_i == tcw_pkg::OP_WRITE) || (req_op_i == tcw_pkg::OP_DISABLE));
		take_init = (state_q == tcw_pkg::ST_IDLE) && init_start_i;
		take_req = (state_q == tcw_pkg::ST_IDLE) && !init_start_i && req_valid_i;
		rel_w = (state_q == tcw_pkg::ST_REL) && !ack_s;
		case (op_q)
			tcw_pkg::OP_INIT: final_w = base_q == INIT_LAST; // RULE_01
			tcw_pkg::OP_WRITE: final_w = off_q == 4'h0; // RULE_09
			tcw_pkg::OP_DISABLE: final_w = off_q == last_q; // RULE_10
			default: final_w = 1'b1;
		endcase
		e_raw = ent_q[off_q*tcw_pkg::ENTRY_W +: tcw_pkg::ENTRY_W];
		m_raw = msk_q[off_q*tcw_pkg::ENTRY_W +: tcw_pkg::ENTRY_W];
		a_raw = act_q[off_q[1:0]*tcw_pkg::ACTION_W +: tcw_pkg::ACTION_W];
		e_tgm = {{(tcw_pkg::ENTRY_W-tcw_pkg::TG_W){1'b0}}, tg.e_msk};
		e_tgv = {{(tcw_pkg::ENTRY_W-tcw_pkg::TG_W){1'b0}}, tg.e_val};
		a_tgm = {{(tcw_pkg::ACTION_W-tcw_pkg::TG_W){1'b0}}, tg.a_msk};
		a_tgv = {{(tcw_pkg::ACTION_W-tcw_pkg::TG_W){1'b0}}, tg.a_val};
	end

	assign tg.offset = off_q;
	assign tg.esize = esize_q;
	assign tg.asize = asize_q;

	// sequencer: takes an operation and walks its addresses
	always_ff @(posedge clk_i or negedge rst_nq) begin
		if (!rst_nq) begin
			state_q <= tcw_pkg::ST_IDLE;
			op_q <= tcw_pkg::OP_INIT;
			base_q <= '0;
			off_q <= '0;
			last_q <= '0;
			esize_q <= '0;
			asize_q <= '0;
			ent_q <= '0;
			msk_q <= '0;
			act_q <= '0;
		end else begin
			case (state_q)
				tcw_pkg::ST_IDLE: begin
					if (take_init) begin
						// clear from address zero upward, one word each
						op_q <= tcw_pkg::OP_INIT;
						base_q <= '0;
						off_q <= '0;
						last_q <= '0;
						state_q <= tcw_pkg::ST_LOAD;
					end else if (take_req && req_ok) begin
						op_q <= tcw_pkg::tcw_op_t'(req_op_i);
						base_q <= req_addr_i;
						last_q <= req_last;
						esize_q <= req_esize_i;
						asize_q <= req_asize_i;
						ent_q <= req_entry_i;
						msk_q <= req_mask_i;
						act_q <= req_action_i;
						// writes start at the top, disables at the bottom
						off_q <= (req_op_i == tcw_pkg::OP_WRITE) ? req_last : 4'h0; // RULE_09 RULE_10
						state_q <= tcw_pkg::ST_LOAD;
					end
				end
				tcw_pkg::ST_LOAD: begin
					state_q <= tcw_pkg::ST_ACK;
				end
				tcw_pkg::ST_ACK: begin
					if (ack_s) begin
						state_q <= tcw_pkg::ST_REL;
					end
				end
				tcw_pkg::ST_REL: begin
					if (rel_w) begin
						if (final_w) begin
							state_q <= tcw_pkg::ST_IDLE;
						end else begin
							// next address of the same operation
							state_q <= tcw_pkg::ST_LOAD;
							case (op_q)
								tcw_pkg::OP_INIT: base_q <= base_q + 13'h0001; // RULE_01
								tcw_pkg::OP_WRITE: off_q <= off_q - 4'h1; // RULE_04 RULE_09
								default: off_q <= off_q + 4'h1; // RULE_04 RULE_10
							endcase
						end
					end
				end
				default: begin
					state_q <= tcw_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// device words: built in the load state, held until ack
	always_ff @(posedge clk_i or negedge rst_nq) begin
		if (!rst_nq) begin
			dev_wr_q <= 1'b0;
			dev_addr_q <= '0;
			dev_entry_q <= '0;
			dev_mask_q <= '0;
			dev_action_q <= '0;
			dev_cnt_q <= '0;
		end else if (state_q == tcw_pkg::ST_LOAD) begin
			dev_wr_q <= 1'b1;
			dev_addr_q <= base_q + {{(tcw_pkg::ADDR_W-tcw_pkg::OFF_W){1'b0}}, off_q}; // RULE_04 RULE_05
			dev_cnt_q <= tcw_pkg::CNT_CLEAR; // RULE_14 RULE_16
			if ((op_q != tcw_pkg::OP_WRITE) || !tg.e_live) begin
				// disabled entry: match-off in every bit
				dev_entry_q <= ENTRY_OFF; // RULE_01 RULE_06 RULE_10 RULE_22
				dev_mask_q <= ENTRY_OFF; // RULE_22
			end else begin
				// marker ones match one, zeros match zero
				dev_entry_q <= (e_raw & ~e_tgm) | e_tgv; // RULE_11 RULE_12
				dev_mask_q <= m_raw & ~e_tgm; // RULE_12
			end
			if ((op_q != tcw_pkg::OP_WRITE) || !tg.a_live) begin
				dev_action_q <= '0; // RULE_01 RULE_06
			end else begin
				dev_action_q <= (a_raw & ~a_tgm) | a_tgv; // RULE_11 RULE_13
			end
		end else if ((state_q == tcw_pkg::ST_ACK) && ack_s) begin
			dev_wr_q <= 1'b0;
		end
	end

	// status pulses and ready level
	always_ff @(posedge clk_i or negedge rst_nq) begin
		if (!rst_nq) begin
			ready_q <= 1'b0;
			done_q <= 1'b0;
			err_q <= 1'b0;
		end else begin
			done_q <= rel_w && final_w;
			err_q <= take_req && !req_ok;
			if (take_init || (take_req && req_ok)) begin
				ready_q <= 1'b0;
			end else if ((state_q == tcw_pkg::ST_IDLE) || (rel_w && final_w)) begin
				ready_q <= 1'b1;
			end
		end
	end

	// bring-up: lookups only after clearing and block allocation
	always_ff @(posedge clk_i or negedge rst_nq) begin
		if (!rst_nq) begin
			init_done_q <= 1'b0;
			lookup_en_q <= 1'b0;
		end else begin
			if (rel_w && final_w && (op_q == tcw_pkg::OP_INIT)) begin
				init_done_q <= 1'b1; // RULE_01
			end
			if (init_done_q && alloc_done_i) begin
				lookup_en_q <= 1'b1; // RULE_02 RULE_03
			end
		end
	end

	assign lookup_en_o = lookup_en_q;
	assign req_ready_o = ready_q;
	assign done_o = done_q;
	assign err_o = err_q;
	assign dev_addr_o = dev_addr_q;
	assign dev_entry_o = dev_entry_q;
	assign dev_mask_o = dev_mask_q;
	assign dev_action_o = dev_action_q;
	assign dev_cnt_o = dev_cnt_q;
	assign dev_wr_o = dev_wr_q;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_nq);

	// last word handshaken, then finish pulse and ready
	sequence s_last_rel;
		rel_w && final_w;
	endsequence
	sequence s_finish;
		done_q && ready_q ##1 !done_q;
	endsequence

	word_hold_a: assert property (dev_wr_q && !ack_s |=> dev_wr_q && $stable(dev_addr_q)) // RULE_04
		else $error("write strobe or address dropped before ack");
	op_finish_a: assert property (s_last_rel |=> s_finish) // RULE_04
		else $error("operation end not reported");
	write_down_a: assert property (rel_w && !final_w && op_q == tcw_pkg::OP_WRITE
		|=> off_q == $past(off_q) - 4'h1 ##2 dev_addr_q == base_q + 13'(off_q)) // RULE_09
		else $error("rule write not descending");
	disable_up_a: assert property (rel_w && !final_w && op_q == tcw_pkg::OP_DISABLE
		|=> off_q == $past(off_q) + 4'h1) // RULE_10
		else $error("rule disable not ascending");
	init_word_a: assert property ($rose(dev_wr_q) && op_q != tcw_pkg::OP_WRITE
		|-> dev_entry_q == ENTRY_OFF && dev_mask_q == ENTRY_OFF && dev_action_q == '0) // RULE_01
		else $error("clear word not disabled and zero");
	cnt_clear_a: assert property (dev_wr_q |-> dev_cnt_q == tcw_pkg::CNT_CLEAR) // RULE_14
		else $error("counter word not zero");
	rule_align_a: assert property ($rose(dev_wr_q) && op_q != tcw_pkg::OP_INIT
		|-> (base_q[3:0] & last_q) == 4'h0 && off_q <= last_q) // RULE_07
		else $error("rule word outside an aligned rule");
	entry_pad_a: assert property ($rose(dev_wr_q) && op_q == tcw_pkg::OP_WRITE && !tg.e_live
		|-> dev_entry_q == ENTRY_OFF && dev_mask_q == ENTRY_OFF) // RULE_06
		else $error("unused entry address not disabled");
	head_mark_a: assert property ($rose(dev_wr_q) && op_q == tcw_pkg::OP_WRITE && off_q == 4'h0
		|-> (dev_entry_q[4:0] & tg.e_msk) == (5'h01 << esize_q)
		&& (dev_mask_q[4:0] & tg.e_msk) == 5'h00) // RULE_18
		else $error("entry head marker wrong");
	lookup_gate_a: assert property ($rose(lookup_en_q) |-> $past(init_done_q) && $past(alloc_done_i)) // RULE_03
		else $error("lookups enabled before bring-up");
endmodule : tcw_host

// ---- tcw_marker.sv ----
// type-group marker encoder for first-stage classifier entries and actions
// assumes sizes already checked against the supported range
`timescale 1ns/1ps
module tcw_marker (
	// lookup request and answer
	tcw_tg_if.enc tg
);
	logic [tcw_pkg::TG_W-1:0] off5; // offset widened to marker width
	logic [tcw_pkg::TG_W-1:0] run; // low bits up to the lowest set offset bit
	logic [tcw_pkg::TG_W-1:0] e_one; // one-hot entry size
	logic [tcw_pkg::TG_W-1:0] a_one; // one-hot action size

	// marker value and width from offset and size
	always_comb begin
		off5 = {1'b0, tg.offset};
		run = off5 ^ (off5 - 5'h01); // RULE_19 RULE_21
		e_one = 5'h01 << tg.esize;
		a_one = 5'h01 << tg.asize;
		tg.e_live = off5 < e_one;
		tg.a_live = off5 < a_one;
		if (tg.offset == 4'h0) begin
			// first address: one-hot size, one bit wider than its log2
			tg.e_val = e_one; // RULE_18
			tg.e_msk = e_one | (e_one - 5'h01); // RULE_18
			tg.a_val = a_one; // RULE_20 RULE_21
			tg.a_msk = a_one | (a_one - 5'h01); // RULE_20 RULE_21
		end else begin
			// later addresses: zeros, width set by offset alignment
			tg.e_val = 5'h00; // RULE_19
			tg.e_msk = run; // RULE_19
			tg.a_val = 5'h00; // RULE_21
			tg.a_msk = run; // RULE_21
		end
	end
endmodule : tcw_marker

// ---- tcw_pkg.sv ----
// constants, states and operations of the ternary match lookup rule programmer
// assumes a one-clock host and a device that takes one cache word per write handshake
// Summary of operation
// RULE_01: initialize every address disabled before enabling lookups
// RULE_02: default rules initialized; device then applies them
// RULE_03: allocate shared blocks before lookups are enabled
// RULE_04: Xn rule fills n consecutive addresses, one write each
// RULE_05: rule size is larger of entry, action sizes
// RULE_06: unused entry addresses disabled, unused actions zero
// RULE_07: Xn rule starts on address multiple of n
// RULE_08: device counts hits at rule offset zero only
// RULE_09: write multi-address rules highest address first
// RULE_10: disable rules starting from lowest address
// RULE_11: type-group marker sits in low word bits
// RULE_12: entry marker in data bits, mask bits zero
// RULE_13: action marker in low action data bits
// RULE_14: counter words never carry a marker
// RULE_15: 1024 addresses per block, 36/70-bit words
// RULE_16: one-bit hit counter saturates at one
// RULE_17: entry sizes X1..X16, action sizes X1..X4
// RULE_18: entry offset zero marker is one-hot size
// RULE_19: entry marker zeros, width by offset alignment
// RULE_20: action offset zero marker 0b1 or 0b10
// RULE_21: action X4 0b100, odd 0b0, offset two 0b00
// RULE_22: data and mask both one means match-off
// RULE_23: wide rule matches only when every address matches
package tcw_pkg;
	localparam int ENTRY_W = 36; // entry and mask bits per address
	localparam int ACTION_W = 70; // action bits per address
	localparam int CNT_W = 1; // hit counter bits per address
	localparam int ADDR_W = 13; // device address bits
	localparam int BLOCK_WORDS = 1024; // addresses per allocated block
	localparam int ADDR_SPACE = 8192; // whole address space, cleared at bring-up
	localparam int OFF_W = 4; // offset inside a rule, up to X16
	localparam int MAX_WORDS = 16; // largest entry, in addresses
	localparam int ACT_WORDS = 4; // largest action, in addresses
	localparam int TG_W = 5; // widest type-group marker
	localparam logic [2:0] ESIZE_MAX = 3'h4; // X16 as log2
	localparam logic [1:0] ASIZE_MAX = 2'h2; // X4 as log2
	localparam logic [CNT_W-1:0] CNT_CLEAR = 1'h0; // counter value written
	// sequencer states, one-hot
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_LOAD = 4'h2,
		ST_ACK = 4'h4,
		ST_REL = 4'h8
	} tcw_state_t;
	// operations run by the sequencer
	typedef enum logic [1:0] {
		OP_INIT = 2'h0,
		OP_WRITE = 2'h1,
		OP_DISABLE = 2'h2
	} tcw_op_t;
endpackage : tcw_pkg

// ---- tcw_sync.sv ----
// two-stage level synchronizer for inputs from outside the clock domain
// assumes an already synchronized active-low reset
`timescale 1ns/1ps
module tcw_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_ni,
	// level in and out
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_q; // first stage, read only by the second
	logic [W-1:0] sync_q; // second stage

	// two flip-flops in a row
	always_ff @(posedge clk_i or negedge rst_ni) begin
		if (!rst_ni) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= d_i;
			sync_q <= meta_q;
		end
	end

	assign q_o = sync_q;
endmodule : tcw_sync

// ---- tcw_tg_if.sv ----
// type-group lookup carrier between the sequencer and the marker encoder
// assumes both ends sit in the same clock domain; the encoder is combinational
`timescale 1ns/1ps
interface tcw_tg_if;
	logic [tcw_pkg::OFF_W-1:0] offset; // address offset inside the rule
	logic [2:0] esize; // entry size, log2 of addresses
	logic [1:0] asize; // action size, log2 of addresses
	logic [tcw_pkg::TG_W-1:0] e_val; // entry marker value
	logic [tcw_pkg::TG_W-1:0] e_msk; // entry marker bit positions
	logic [tcw_pkg::TG_W-1:0] a_val; // action marker value
	logic [tcw_pkg::TG_W-1:0] a_msk; // action marker bit positions
	logic e_live; // offset lies inside the entry
	logic a_live; // offset lies inside the action
	// sequencer side
	modport ctrl (output offset, esize, asize, input e_val, e_msk, a_val, a_msk, e_live, a_live);
	// encoder side
	modport enc (input offset, esize, asize, output e_val, e_msk, a_val, a_msk, e_live, a_live);
endinterface : tcw_tg_if
